// [core/lbcr_pkg.sv]
// constants for the lighting bus control register bank
package lbcr_pkg;
    localparam logic [15:0] ADDR_RX_CNT = 16'h7617;
    localparam logic [15:0] ADDR_ERR_CNT = 16'h761f;
    localparam logic [15:0] ADDR_TX_CNT = 16'h7627;
    localparam logic [15:0] ADDR_BUS1_CFG = 16'h9d3e;
    localparam logic [15:0] ADDR_BUS2_CFG = 16'h9d3f;
    localparam logic [15:0] ADDR_BUS1_LEVEL = 16'h9d4a;
    localparam logic [15:0] ADDR_BUS1_SPEED = 16'h9e0e;
    localparam logic [15:0] ADDR_BUS1_FTIME = 16'h9e12;
    localparam logic [15:0] ADDR_BUS1_PON = 16'h9e16;
    localparam logic [15:0] ADDR_BUS1_FAIL = 16'h9e1a;
    localparam logic [15:0] ADDR_LOW_WORD = 16'h0001;

    localparam int CFG1_SENSOR_BIT = 3;
    localparam int CFG1_DIMOFF_BIT = 4;
    localparam int CFG2_LIT_BIT = 0;
    localparam int CFG2_RECALL_BIT = 1;
    localparam int CFG2_OFF_BIT = 2;

    localparam logic SENSOR_EN_RST = 1'b1;
    localparam logic DIMOFF_RST = 1'b0;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [3:0] SPEED_RST = 4'h7;
    localparam logic [3:0] FTIME_RST = 4'h0;
    localparam logic [7:0] PON_RST = 8'hfe;
    localparam logic [7:0] FAIL_RST = 8'hfe;
    localparam logic [15:0] LEVEL_MAX = 16'h00fe;
    localparam logic [15:0] CODE_MAX = 16'h000f;

    typedef enum logic [1:0] {
        LBCR_CMD_LEVEL,
        LBCR_CMD_PON,
        LBCR_CMD_FAIL
    } lbcr_cmd_type;
endpackage : lbcr_pkg

// [core/lbcr_frame_counter.sv]
// free-running wrapping event counter
module lbcr_frame_counter #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic inc,
    output logic [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;

    // wraps to zero past all ones
    assign nxt_count = count_ff + WIDTH'(1);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= '0;
        end else if (ce && inc) begin
            count_ff <= nxt_count;
        end
    end

    assign count = count_ff;
endmodule : lbcr_frame_counter

// [core/lbcr_regs.sv]
// register bank and command launch for the two-channel lighting controller
module lbcr_regs #(
    parameter int CNT_WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic occupancy_sensor1_pin,
    input wire logic switch_input1_pin,
    input wire logic joint_by_switch_input_two,
    input wire logic [3:0] bus2_switch_fade_speed,
    input wire logic [3:0] bus2_host_fade_duration,
    output logic occupancy_sensor1_active,
    output logic sw1_toggle,
    output logic sw1_dim_hold,
    output logic [3:0] sw1_fade_speed,
    output logic bus1_cmd_valid,
    output lbcr_pkg::lbcr_cmd_type bus1_cmd_kind,
    output logic [7:0] bus1_cmd_arg,
    output logic [3:0] bus1_cmd_fade,
    output logic bus1_cmd_broadcast,
    input wire logic bus1_cmd_ready,
    output logic bus2_cmd_valid,
    output logic bus2_cmd_off,
    input wire logic bus2_cmd_ready,
    input wire logic bus2_rx_ok,
    input wire logic bus2_rx_err,
    input wire logic bus2_tx_done
);
    logic sensor_en_ff;
    logic dimoff_ff;
    logic [7:0] level_ff;
    logic [3:0] speed_ff;
    logic [3:0] ftime_ff;
    logic [7:0] pon_ff;
    logic [7:0] fail_ff;
    logic [2:0] sensor_sync_ff;
    logic [2:0] switch_sync_ff;
    logic sensor_stable_ff;
    logic switch_stable_ff;
    logic sw_prev_ff;
    logic sensor_act_ff;
    logic toggle_ff;
    logic dim_hold_ff;
    logic [3:0] fade_out_ff;
    logic [2:0] pend1_ff;
    logic cmd1_valid_ff;
    lbcr_pkg::lbcr_cmd_type cmd1_kind_ff;
    logic [7:0] cmd1_arg_ff;
    logic [3:0] cmd1_fade_ff;
    logic lit2_ff;
    logic recall_bit_ff;
    logic off_bit_ff;
    logic pend2_ff;
    logic pend2_off_ff;
    logic cmd2_valid_ff;
    logic cmd2_off_ff;
    logic [15:0] rdata_ff;
    logic [CNT_WIDTH-1:0] rx_cnt;
    logic [CNT_WIDTH-1:0] err_cnt;
    logic [CNT_WIDTH-1:0] tx_cnt;

    // address decode
    wire wr_cfg1 = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS1_CFG);
    wire wr_cfg2 = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS2_CFG);
    wire wr_level = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS1_LEVEL);
    wire wr_speed = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS1_SPEED);
    wire wr_ftime = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS1_FTIME);
    wire wr_pon = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS1_PON);
    wire wr_fail = reg_wr && (reg_addr == lbcr_pkg::ADDR_BUS1_FAIL);
    // out-of-range values are refused, not clipped
    wire level_ok = reg_wdata <= lbcr_pkg::LEVEL_MAX;
    wire code_ok = reg_wdata <= lbcr_pkg::CODE_MAX;

    // switch and sensor behaviour
    wire sw_press = switch_stable_ff && !toggle_ff && !sw_prev_ff;
    wire nxt_sensor_act = sensor_stable_ff && sensor_en_ff;
    wire nxt_dim_hold = switch_stable_ff && !dimoff_ff;
    // joint control borrows channel 2 codes
    wire [3:0] eff_speed = joint_by_switch_input_two ?
        bus2_switch_fade_speed : speed_ff;
    wire [3:0] eff_ftime = joint_by_switch_input_two ?
        bus2_host_fade_duration : ftime_ff;

    // channel 1 command launch; a new write re-arms, set beats load
    wire [2:0] set1 = {wr_fail && level_ok, wr_pon && level_ok,
                       wr_level && level_ok};
    wire load1 = !cmd1_valid_ff && (pend1_ff != 3'h0);
    wire [2:0] pick1 = pend1_ff[0] ? 3'h1 : pend1_ff[1] ? 3'h2 : 3'h4;
    wire [2:0] nxt_pend1 = (pend1_ff & ~(load1 ? pick1 : 3'h0)) | set1;
    wire lbcr_pkg::lbcr_cmd_type pick_kind = pend1_ff[0] ?
        lbcr_pkg::LBCR_CMD_LEVEL : pend1_ff[1] ? lbcr_pkg::LBCR_CMD_PON :
        lbcr_pkg::LBCR_CMD_FAIL;
    wire [7:0] pick_arg = pend1_ff[0] ? level_ff : pend1_ff[1] ? pon_ff :
        fail_ff;
    wire done1 = cmd1_valid_ff && bus1_cmd_ready;

    // channel 2 edges against stored bits
    wire lit_rise = reg_wdata[lbcr_pkg::CFG2_LIT_BIT] && !lit2_ff;
    wire lit_fall = !reg_wdata[lbcr_pkg::CFG2_LIT_BIT] && lit2_ff;
    wire recall_edge = reg_wdata[lbcr_pkg::CFG2_RECALL_BIT] &&
        !recall_bit_ff;
    wire off_edge = reg_wdata[lbcr_pkg::CFG2_OFF_BIT] && !off_bit_ff;
    // off wins when one write asks for both
    wire want_off = wr_cfg2 && (off_edge || lit_fall);
    wire want_recall = wr_cfg2 && (recall_edge || lit_rise) && !want_off;
    wire nxt_lit2 = want_off ? 1'b0 : want_recall ? 1'b1 : lit2_ff;
    wire load2 = pend2_ff && !cmd2_valid_ff;
    wire done2 = cmd2_valid_ff && bus2_cmd_ready;

    // register read mux; unmapped reads give zero
    wire [15:0] rd_cfg1 = {11'h000, dimoff_ff, sensor_en_ff, 3'h0};
    wire [15:0] rd_cfg2 = {13'h0000, off_bit_ff, recall_bit_ff, lit2_ff};
    wire [15:0] rd_mux =
        (reg_addr == lbcr_pkg::ADDR_RX_CNT) ? rx_cnt[31:16] :
        (reg_addr == lbcr_pkg::ADDR_RX_CNT + lbcr_pkg::ADDR_LOW_WORD) ?
            rx_cnt[15:0] :
        (reg_addr == lbcr_pkg::ADDR_ERR_CNT) ? err_cnt[31:16] :
        (reg_addr == lbcr_pkg::ADDR_ERR_CNT + lbcr_pkg::ADDR_LOW_WORD) ?
            err_cnt[15:0] :
        (reg_addr == lbcr_pkg::ADDR_TX_CNT) ? tx_cnt[31:16] :
        (reg_addr == lbcr_pkg::ADDR_TX_CNT + lbcr_pkg::ADDR_LOW_WORD) ?
            tx_cnt[15:0] :
        (reg_addr == lbcr_pkg::ADDR_BUS1_CFG) ? rd_cfg1 :
        (reg_addr == lbcr_pkg::ADDR_BUS2_CFG) ? rd_cfg2 :
        (reg_addr == lbcr_pkg::ADDR_BUS1_LEVEL) ? {8'h00, level_ff} :
        (reg_addr == lbcr_pkg::ADDR_BUS1_SPEED) ? {12'h000, speed_ff} :
        (reg_addr == lbcr_pkg::ADDR_BUS1_FTIME) ? {12'h000, ftime_ff} :
        (reg_addr == lbcr_pkg::ADDR_BUS1_PON) ? {8'h00, pon_ff} :
        (reg_addr == lbcr_pkg::ADDR_BUS1_FAIL) ? {8'h00, fail_ff} : 16'h0000;

    // software registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_en_ff <= lbcr_pkg::SENSOR_EN_RST;
            dimoff_ff <= lbcr_pkg::DIMOFF_RST;
            level_ff <= lbcr_pkg::LEVEL_RST;
            speed_ff <= lbcr_pkg::SPEED_RST;
            ftime_ff <= lbcr_pkg::FTIME_RST;
            pon_ff <= lbcr_pkg::PON_RST;
            fail_ff <= lbcr_pkg::FAIL_RST;
        end else if (ce) begin
            if (wr_cfg1) begin
                sensor_en_ff <= reg_wdata[lbcr_pkg::CFG1_SENSOR_BIT];
                dimoff_ff <= reg_wdata[lbcr_pkg::CFG1_DIMOFF_BIT];
            end
            if (wr_level && level_ok) level_ff <= reg_wdata[7:0];
            if (wr_speed && code_ok) speed_ff <= reg_wdata[3:0];
            if (wr_ftime && code_ok) ftime_ff <= reg_wdata[3:0];
            if (wr_pon && level_ok) pon_ff <= reg_wdata[7:0];
            if (wr_fail && level_ok) fail_ff <= reg_wdata[7:0];
        end
    end

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_sync_ff <= 3'h0;
            switch_sync_ff <= 3'h0;
            sensor_stable_ff <= 1'b0;
            switch_stable_ff <= 1'b0;
        end else if (ce) begin
            sensor_sync_ff <= {sensor_sync_ff[1:0], occupancy_sensor1_pin};
            switch_sync_ff <= {switch_sync_ff[1:0], switch_input1_pin};
            if (sensor_sync_ff[1] == sensor_sync_ff[2])
                sensor_stable_ff <= sensor_sync_ff[2];
            if (switch_sync_ff[1] == switch_sync_ff[2])
                switch_stable_ff <= switch_sync_ff[2];
        end
    end

    // switch and sensor outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sw_prev_ff <= 1'b0;
            sensor_act_ff <= 1'b0;
            toggle_ff <= 1'b0;
            dim_hold_ff <= 1'b0;
            fade_out_ff <= lbcr_pkg::SPEED_RST;
        end else if (ce) begin
            sw_prev_ff <= switch_stable_ff;
            sensor_act_ff <= nxt_sensor_act;
            toggle_ff <= sw_press;
            dim_hold_ff <= nxt_dim_hold;
            fade_out_ff <= eff_speed;
        end
    end

    // channel 1 command slot, held until taken
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend1_ff <= 3'h0;
            cmd1_valid_ff <= 1'b0;
            cmd1_kind_ff <= lbcr_pkg::LBCR_CMD_LEVEL;
            cmd1_arg_ff <= 8'h00;
            cmd1_fade_ff <= 4'h0;
        end else if (ce) begin
            pend1_ff <= nxt_pend1;
            if (load1) begin
                cmd1_valid_ff <= 1'b1;
                cmd1_kind_ff <= pick_kind;
                cmd1_arg_ff <= pick_arg;
                cmd1_fade_ff <= eff_ftime;
            end else if (done1) begin
                cmd1_valid_ff <= 1'b0;
            end
        end
    end

    // channel 2 state and command slot; newest request replaces older
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lit2_ff <= 1'b0;
            recall_bit_ff <= 1'b0;
            off_bit_ff <= 1'b0;
            pend2_ff <= 1'b0;
            pend2_off_ff <= 1'b0;
            cmd2_valid_ff <= 1'b0;
            cmd2_off_ff <= 1'b0;
        end else if (ce) begin
            lit2_ff <= nxt_lit2;
            if (wr_cfg2) begin
                recall_bit_ff <= reg_wdata[lbcr_pkg::CFG2_RECALL_BIT];
                off_bit_ff <= reg_wdata[lbcr_pkg::CFG2_OFF_BIT];
            end
            if (want_off || want_recall) begin
                pend2_ff <= 1'b1;
                pend2_off_ff <= want_off;
            end else if (load2) begin
                pend2_ff <= 1'b0;
            end
            if (load2) begin
                cmd2_valid_ff <= 1'b1;
                cmd2_off_ff <= pend2_off_ff;
            end else if (done2) begin
                cmd2_valid_ff <= 1'b0;
            end
        end
    end

    // read data register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 16'h0000;
        end else if (ce && reg_rd) begin
            rdata_ff <= rd_mux;
        end
    end

    lbcr_frame_counter #(.WIDTH(CNT_WIDTH)) u_rx_cnt (.ref_clk(ref_clk),
        .rstn(rstn), .ce(ce), .inc(bus2_rx_ok), .count(rx_cnt));
    lbcr_frame_counter #(.WIDTH(CNT_WIDTH)) u_err_cnt (.ref_clk(ref_clk),
        .rstn(rstn), .ce(ce), .inc(bus2_rx_err), .count(err_cnt));
    lbcr_frame_counter #(.WIDTH(CNT_WIDTH)) u_tx_cnt (.ref_clk(ref_clk),
        .rstn(rstn), .ce(ce), .inc(bus2_tx_done), .count(tx_cnt));
    assign reg_rdata = rdata_ff;
    assign occupancy_sensor1_active = sensor_act_ff;
    assign sw1_toggle = toggle_ff;
    assign sw1_dim_hold = dim_hold_ff;
    assign sw1_fade_speed = fade_out_ff;
    assign bus1_cmd_valid = cmd1_valid_ff;
    assign bus1_cmd_kind = cmd1_kind_ff;
    assign bus1_cmd_arg = cmd1_arg_ff;
    assign bus1_cmd_fade = cmd1_fade_ff;
    // no short addresses exist, so every command is a broadcast
    assign bus1_cmd_broadcast = 1'b1;
    assign bus2_cmd_valid = cmd2_valid_ff;
    assign bus2_cmd_off = cmd2_off_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_sensor_gate;
        occupancy_sensor1_active |-> $past(sensor_en_ff);
    endproperty
    a_sensor_gate: assert property (p_sensor_gate)
        else $error("sensor active while disabled");
    property p_no_dim;
        dimoff_ff && $past(dimoff_ff) |-> !sw1_dim_hold;
    endproperty
    a_no_dim: assert property (p_no_dim)
        else $error("dimming while disabled");
    property p_level_range;
        level_ff <= 8'hfe;
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("broadcast level above 254");
    property p_level_cmd;
        ce && wr_level && level_ok |=> pend1_ff[0];
    endproperty
    a_level_cmd: assert property (p_level_cmd)
        else $error("level write did not queue a command");
    property p_speed_refuse;
        ce && wr_speed && !code_ok |=> speed_ff == $past(speed_ff);
    endproperty
    a_speed_refuse: assert property (p_speed_refuse)
        else $error("illegal fade code stored");
    property p_joint_speed;
        ce && joint_by_switch_input_two |=>
            sw1_fade_speed == $past(bus2_switch_fade_speed);
    endproperty
    a_joint_speed: assert property (p_joint_speed)
        else $error("joint mode not using channel 2 speed");
    property p_joint_ftime;
        ce && load1 && joint_by_switch_input_two |=>
            bus1_cmd_fade == $past(bus2_host_fade_duration);
    endproperty
    a_joint_ftime: assert property (p_joint_ftime)
        else $error("joint mode not using channel 2 fade time");
    property p_lit_fall;
        ce && wr_cfg2 && lit2_ff && !reg_wdata[0] |=>
            !lit2_ff && pend2_ff && pend2_off_ff ##1
            !ce || bus2_cmd_valid;
    endproperty
    a_lit_fall: assert property (p_lit_fall)
        else $error("lit bit clear did not send off");
    property p_recall_edge;
        ce && wr_cfg2 && !recall_bit_ff && reg_wdata[1] && !off_edge &&
            !lit_fall |=> pend2_ff && !pend2_off_ff && lit2_ff;
    endproperty
    a_recall_edge: assert property (p_recall_edge)
        else $error("recall edge not sent");
    property p_hold2;
        ce && bus2_cmd_valid && !bus2_cmd_ready |=>
            bus2_cmd_valid && $stable(bus2_cmd_off);
    endproperty
    a_hold2: assert property (p_hold2)
        else $error("channel 2 command dropped");
    property p_rx_count;
        ce && bus2_rx_ok |=> rx_cnt == $past(rx_cnt) + 32'h1;
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("rx counter missed a frame");
    c_off_sent: cover property (bus2_cmd_valid && bus2_cmd_off &&
        bus2_cmd_ready);
    c_lvl_sent: cover property (bus1_cmd_valid && bus1_cmd_ready &&
        bus1_cmd_kind == lbcr_pkg::LBCR_CMD_LEVEL);
    c_toggle: cover property (sw1_toggle && dimoff_ff);
endmodule : lbcr_regs

// [testbench/lbcr_ballast_model.sv]
// ballast side model taking bus 1 and bus 2 commands
module lbcr_ballast_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] dly,
    input wire logic bus1_cmd_valid,
    input wire lbcr_pkg::lbcr_cmd_type bus1_cmd_kind,
    input wire logic [7:0] bus1_cmd_arg,
    input wire logic [3:0] bus1_cmd_fade,
    input wire logic bus1_cmd_broadcast,
    output logic bus1_cmd_ready,
    input wire logic bus2_cmd_valid,
    input wire logic bus2_cmd_off,
    output logic bus2_cmd_ready,
    output logic bus2_tx_done,
    output int n1,
    output int n2,
    output logic [15:0] last1,
    output logic last2_off
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] w1;
    logic [3:0] w2;
    // ready is raised only after dly cycles, so slow answers are exercised
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bus1_cmd_ready <= 1'b0;
            bus2_cmd_ready <= 1'b0;
            bus2_tx_done <= 1'b0;
            w1 <= 4'h0;
            w2 <= 4'h0;
            n1 <= 0;
            n2 <= 0;
        end else begin
            bus2_tx_done <= 1'b0;
            if (bus1_cmd_valid && bus1_cmd_ready) begin
                // ballasts act on broadcast only, no short addresses known
                if (bus1_cmd_broadcast) begin
                    last1 <= {2'h0, bus1_cmd_kind, bus1_cmd_fade, bus1_cmd_arg};
                    n1 <= n1 + 1;
                end
                bus1_cmd_ready <= 1'b0;
                w1 <= 4'h0;
            end else if (bus1_cmd_valid) begin
                w1 <= w1 + 4'h1;
                bus1_cmd_ready <= (w1 >= dly);
            end
            if (bus2_cmd_valid && bus2_cmd_ready) begin
                last2_off <= bus2_cmd_off;
                n2 <= n2 + 1;
                bus2_tx_done <= 1'b1;
                bus2_cmd_ready <= 1'b0;
                w2 <= 4'h0;
            end else if (bus2_cmd_valid) begin
                w2 <= w2 + 4'h1;
                bus2_cmd_ready <= (w2 >= dly);
            end
        end
    end
endmodule : lbcr_ballast_model

// [testbench/lighting_bus_control_regs_tb.sv]
// self-checking bench for the lighting bus register bank
module lighting_bus_control_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic sens = 1'b0;
    logic sw = 1'b0;
    logic joint = 1'b0;
    logic [3:0] spd2 = 4'h3;
    logic [3:0] dur2 = 4'h9;
    logic [3:0] dly = 4'h0;
    logic ce = 1'b1;
    logic sens_act, sw_tog, sw_hold;
    logic [3:0] sw_spd;
    logic b1v, b1bc, b1r, b2v, b2off, b2r, rx_ok = 1'b0, rx_err = 1'b0, txd;
    lbcr_pkg::lbcr_cmd_type b1k;
    logic [7:0] b1a;
    logic [3:0] b1f;
    int n1, n2;
    logic [15:0] last1;
    logic last2_off;
    int n_errors = 0;
    int checks_done = 0;
    logic [15:0] rv;

    lbcr_regs #(.CNT_WIDTH(32)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .occupancy_sensor1_pin(sens),
        .switch_input1_pin(sw), .joint_by_switch_input_two(joint),
        .bus2_switch_fade_speed(spd2), .bus2_host_fade_duration(dur2),
        .occupancy_sensor1_active(sens_act), .sw1_toggle(sw_tog),
        .sw1_dim_hold(sw_hold), .sw1_fade_speed(sw_spd),
        .bus1_cmd_valid(b1v), .bus1_cmd_kind(b1k), .bus1_cmd_arg(b1a),
        .bus1_cmd_fade(b1f), .bus1_cmd_broadcast(b1bc), .bus1_cmd_ready(b1r),
        .bus2_cmd_valid(b2v), .bus2_cmd_off(b2off), .bus2_cmd_ready(b2r),
        .bus2_rx_ok(rx_ok), .bus2_rx_err(rx_err), .bus2_tx_done(txd));

    lbcr_ballast_model i_ballast (
        .ref_clk(ref_clk), .rstn(rstn), .dly(dly), .bus1_cmd_valid(b1v),
        .bus1_cmd_kind(b1k), .bus1_cmd_arg(b1a), .bus1_cmd_fade(b1f),
        .bus1_cmd_broadcast(b1bc), .bus1_cmd_ready(b1r),
        .bus2_cmd_valid(b2v), .bus2_cmd_off(b2off), .bus2_cmd_ready(b2r),
        .bus2_tx_done(txd), .n1(n1), .n2(n2), .last1(last1),
        .last2_off(last2_off));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk

    // one access per call; strobe dropped one edge after it was raised
    task automatic acc(logic wr, logic [15:0] a, logic [15:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rv = reg_rdata;
    endtask : acc

    task automatic rd_chk(string what, logic [15:0] a, logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk(what, exp, rv);
    endtask : rd_chk

    // bounded wait on a ballast model command count, bus 1 or bus 2
    task automatic wait_cnt(logic bus2, int goal);
        for (int i = 0; i < 60 && (bus2 ? n2 : n1) < goal; i++)
            @(posedge ref_clk);
        #1;
        if ((bus2 ? n2 : n1) < goal) begin
            $display("ERROR command wait expected %0d seen %0d", goal,
                bus2 ? n2 : n1);
            n_errors++;
            end_of_test();
        end
    endtask : wait_cnt

    task automatic t_reset;
        rd_chk("cfg1", lbcr_pkg::ADDR_BUS1_CFG, 16'h0008);
        rd_chk("level", lbcr_pkg::ADDR_BUS1_LEVEL, 16'h0000);
        rd_chk("speed", lbcr_pkg::ADDR_BUS1_SPEED, 16'h0007);
        rd_chk("ftime", lbcr_pkg::ADDR_BUS1_FTIME, 16'h0000);
        rd_chk("cfg2", lbcr_pkg::ADDR_BUS2_CFG, 16'h0000);
        rd_chk("pon", lbcr_pkg::ADDR_BUS1_PON, 16'h00fe);
        rd_chk("fail", lbcr_pkg::ADDR_BUS1_FAIL, 16'h00fe);
        rd_chk("rx_lo", lbcr_pkg::ADDR_RX_CNT + 16'h1, 16'h0000);
        chk("sw_spd", 16'h7, {12'h0, sw_spd});
    endtask : t_reset

    task automatic t_level;
        acc(1'b1, lbcr_pkg::ADDR_BUS1_FTIME, 16'h0005);
        // out-of-range fade time must leave code 5 in place
        acc(1'b1, lbcr_pkg::ADDR_BUS1_FTIME, 16'h0010);
        acc(1'b1, lbcr_pkg::ADDR_BUS1_LEVEL, 16'h00fe);
        wait_cnt(1'b0, 1);
        chk("cmd_level", 16'h05fe, last1);
        acc(1'b1, lbcr_pkg::ADDR_BUS1_LEVEL, 16'h00ff);
        rd_chk("level", lbcr_pkg::ADDR_BUS1_LEVEL, 16'h00fe);
        joint = 1'b1;
        acc(1'b1, lbcr_pkg::ADDR_BUS1_LEVEL, 16'h0000);
        wait_cnt(1'b0, 2);
        chk("cmd_joint", 16'h0900, last1);
        chk("n1", 16'h2, n1[15:0]);
        chk("sw_spd", {12'h0, spd2}, {12'h0, sw_spd});
        joint = 1'b0;
    endtask : t_level

    task automatic t_store;
        dly = 4'h5;
        acc(1'b1, lbcr_pkg::ADDR_BUS1_PON, 16'h0010);
        acc(1'b1, lbcr_pkg::ADDR_BUS1_FAIL, 16'h0020);
        wait_cnt(1'b0, 3);
        chk("cmd_pon", 16'h1510, last1);
        wait_cnt(1'b0, 4);
        chk("cmd_fail", 16'h2520, last1);
        dly = 4'h0;
        acc(1'b1, lbcr_pkg::ADDR_BUS1_SPEED, 16'h000f);
        acc(1'b1, lbcr_pkg::ADDR_BUS1_SPEED, 16'h0010);
        rd_chk("speed", lbcr_pkg::ADDR_BUS1_SPEED, 16'h000f);
        chk("sw_spd", 16'hf, {12'h0, sw_spd});
    endtask : t_store

    // one press: a single toggle, hold only with dimming allowed
    task automatic press(logic dim_off);
        int tog;
        logic held;
        tog = 0;
        held = 1'b0;
        sw = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk) #1;
            tog += sw_tog;
            held |= sw_hold;
        end
        chk("toggles", 16'h1, tog[15:0]);
        chk("hold", {15'h0, !dim_off}, {15'h0, held});
        sw = 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask : press

    task automatic t_inputs;
        sens = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 chk("sens_on", 16'h1, {15'h0, sens_act});
        press(1'b0);
        acc(1'b1, lbcr_pkg::ADDR_BUS1_CFG, 16'h0010);
        repeat (2) @(posedge ref_clk);
        #1 chk("sens_off", 16'h0, {15'h0, sens_act});
        press(1'b1);
        sens = 1'b0;
    endtask : t_inputs

    task automatic t_bus2;
        logic [15:0] wd [4] = '{16'h0001, 16'h0000, 16'h0002, 16'h0006};
        logic [15:0] rb [4] = '{16'h0001, 16'h0000, 16'h0003, 16'h0006};
        logic ex_off [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, lbcr_pkg::ADDR_BUS2_CFG, wd[i]);
            wait_cnt(1'b1, i + 1);
            chk("cmd_off", {15'h0, ex_off[i]}, {15'h0, last2_off});
            rd_chk("cfg2", lbcr_pkg::ADDR_BUS2_CFG, rb[i]);
        end
        // same value again holds no edge, so nothing goes out
        acc(1'b1, lbcr_pkg::ADDR_BUS2_CFG, 16'h0006);
        repeat (10) @(posedge ref_clk);
        #1 chk("n2", 16'h4, n2[15:0]);
    endtask : t_bus2

    task automatic t_count;
        @(posedge ref_clk) #1;
        rx_ok = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 rx_ok = 1'b0;
        rx_err = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 rx_err = 1'b0;
        rd_chk("rx_hi", lbcr_pkg::ADDR_RX_CNT, 16'h0000);
        rd_chk("rx_lo", lbcr_pkg::ADDR_RX_CNT + 16'h1, 16'h0003);
        rd_chk("err_lo", lbcr_pkg::ADDR_ERR_CNT + 16'h1, 16'h0002);
        rd_chk("tx_lo", lbcr_pkg::ADDR_TX_CNT + 16'h1, 16'h0004);
        // frozen clock enable must swallow frame pulses
        ce = 1'b0;
        rx_ok = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 rx_ok = 1'b0;
        ce = 1'b1;
        rd_chk("rx_frozen", lbcr_pkg::ADDR_RX_CNT + 16'h1, 16'h0003);
        acc(1'b1, lbcr_pkg::ADDR_RX_CNT + 16'h1, 16'h1234);
        rd_chk("rx_ro", lbcr_pkg::ADDR_RX_CNT + 16'h1, 16'h0003);
    endtask : t_count

    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1'b1;
        t_reset();
        t_level();
        t_store();
        t_inputs();
        t_bus2();
        t_count();
        end_of_test();
    end
endmodule : lighting_bus_control_regs_tb
